// File: cfm_consts.svh
// Constants for the charger fault mask and converter setup register bank.
// Assumes the including file uses these names for offsets, fields and reset values.
`ifndef CFM_CONSTS_SVH
`define CFM_CONSTS_SVH

// Register offsets
`define CFM_OFF_MASK_A      8'h2C
`define CFM_OFF_MASK_B      8'h2D
`define CFM_OFF_SETUP       8'h2E
`define CFM_OFF_CHAN_A      8'h2F

// Reset values
`define CFM_RST_MASK_A      8'h00
`define CFM_RST_MASK_B      8'h00
`define CFM_RST_SETUP       8'h30
`define CFM_RST_CHAN_A      8'h00

// Writable bit masks
`define CFM_WMASK_MASK_A    8'hFF
`define CFM_WMASK_MASK_B    8'hFC
`define CFM_WMASK_SETUP     8'hFF
`define CFM_WMASK_CHAN_A    8'hFE

// Field positions in the converter setup register
`define CFM_BIT_ENABLE      7
`define CFM_BIT_ONESHOT     6
`define CFM_BIT_SPEED_HI    5
`define CFM_BIT_SPEED_LO    4
`define CFM_BIT_AVG         3
`define CFM_BIT_AVG_SEED    2

// Field positions in the second fault mask register
`define CFM_BIT_SYS_SHORT   7
`define CFM_BIT_SYS_OV      6
`define CFM_BIT_REV_OV      5
`define CFM_BIT_REV_UV      4
`define CFM_BIT_THERMAL     2

`endif

// File: cfm_pkg.sv
// Types for the charger fault mask and converter setup register bank.
// Assumes no other package.
package cfm_pkg;
	// Effective resolution codes
	typedef enum logic [1:0] {
		CFM_RES_15 = 2'h0,
		CFM_RES_14 = 2'h1,
		CFM_RES_13 = 2'h2,
		CFM_RES_12 = 2'h3
	} cfm_res_e;
endpackage

// File: cfm_bank.sv
// Fault interrupt masks, converter setup and channel disable registers.
// Assumes an I2C slave elsewhere presents one-cycle synchronous read and write strobes.
`include "cfm_consts.svh"

module cfm_bank (
	// Clock and reset
	input  wire logic       i_clock,
	input  wire logic       i_rst,
	// Register access port
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	output logic            o_rdata_valid,
	output logic            o_addr_hit,
	// Reset sources
	input  wire logic       i_reg_reset,
	input  wire logic       i_watchdog_expired,
	// Protection events, one-cycle pulses
	input  wire logic [7:0] i_fault_a_evt,
	input  wire logic [7:0] i_fault_b_evt,
	input  wire logic       i_conv_done_evt,
	input  wire logic       i_conv_done_irq_off,
	// Interrupt pulse
	output logic            o_irq_pulse,
	// Converter configuration outputs
	output logic            o_conv_enable,
	output logic            o_conv_oneshot,
	output cfm_pkg::cfm_res_e o_conv_resolution,
	output logic            o_average_select,
	output logic            o_average_seed_select,
	output logic      [6:0] o_chan_off
);

	// Register storage
	logic [7:0] mask_a_q;   // First fault mask
	logic [7:0] mask_b_q;   // Second fault mask
	logic [7:0] setup_q;    // Converter setup
	logic [7:0] chan_q;     // Channel disable
	logic [7:0] rdata_q;    // Read data
	logic       rvalid_q;   // Read data valid
	logic       irq_q;      // Interrupt pulse
	logic       write_ok;   // Write accepted

	// Write blocked while the register reset stands
	assign write_ok = i_wr && !i_reg_reset;

	// Write strobe aimed at one register offset; shared by all four registers
	function automatic logic cfm_sel(
		input logic       wr,
		input logic [7:0] addr,
		input logic [7:0] off
	);
		return wr && (addr == off);
	endfunction

	// First fault mask, fully writable
	always_ff @(posedge i_clock) begin
		if (i_rst || i_reg_reset) begin
			mask_a_q <= `CFM_RST_MASK_A;
		end else if (cfm_sel(write_ok, i_addr, `CFM_OFF_MASK_A)) begin
			mask_a_q <= i_wdata & `CFM_WMASK_MASK_A;
		end
	end

	// Second fault mask, bits 1-0 held at zero
	always_ff @(posedge i_clock) begin
		if (i_rst || i_reg_reset) begin
			mask_b_q <= `CFM_RST_MASK_B;
		end else if (cfm_sel(write_ok, i_addr, `CFM_OFF_MASK_B)) begin
			mask_b_q <= i_wdata & `CFM_WMASK_MASK_B;
		end
	end

	// Converter setup; watchdog clears only the enable bit
	always_ff @(posedge i_clock) begin
		if (i_rst || i_reg_reset) begin
			setup_q <= `CFM_RST_SETUP;
		end else if (cfm_sel(write_ok, i_addr, `CFM_OFF_SETUP)) begin
			setup_q <= i_wdata & `CFM_WMASK_SETUP;
			if (i_watchdog_expired) begin
				setup_q[`CFM_BIT_ENABLE] <= 1'b0;
			end
		end else if (i_watchdog_expired) begin
			setup_q[`CFM_BIT_ENABLE] <= 1'b0;
		end
	end

	// Channel disable, bit 0 held at zero
	always_ff @(posedge i_clock) begin
		if (i_rst || i_reg_reset) begin
			chan_q <= `CFM_RST_CHAN_A;
		end else if (cfm_sel(write_ok, i_addr, `CFM_OFF_CHAN_A)) begin
			chan_q <= i_wdata & `CFM_WMASK_CHAN_A;
		end
	end

	// Read path, registered, unmapped reads zero
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_rd;
			if (i_rd) begin
				unique case (i_addr)
					`CFM_OFF_MASK_A: rdata_q <= mask_a_q;
					`CFM_OFF_MASK_B: rdata_q <= mask_b_q;
					`CFM_OFF_SETUP:  rdata_q <= setup_q;
					`CFM_OFF_CHAN_A: rdata_q <= chan_q;
					default:         rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// Interrupt pulse: unmasked event on a writable mask bit, or done in one-shot mode while done irq is not off
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|(i_fault_a_evt & ~mask_a_q))
				|| (|(i_fault_b_evt & ~mask_b_q & `CFM_WMASK_MASK_B))
				|| (i_conv_done_evt && setup_q[`CFM_BIT_ONESHOT]
					&& !i_conv_done_irq_off);
		end
	end

	// Output drive
	assign o_rdata               = rdata_q;
	assign o_rdata_valid         = rvalid_q;
	assign o_addr_hit            = (i_addr >= `CFM_OFF_MASK_A) && (i_addr <= `CFM_OFF_CHAN_A);
	assign o_irq_pulse           = irq_q;
	assign o_conv_enable         = setup_q[`CFM_BIT_ENABLE];
	assign o_conv_oneshot        = setup_q[`CFM_BIT_ONESHOT];
	assign o_conv_resolution     = cfm_pkg::cfm_res_e'(setup_q[`CFM_BIT_SPEED_HI:`CFM_BIT_SPEED_LO]);
	assign o_average_select      = setup_q[`CFM_BIT_AVG];
	assign o_average_seed_select = setup_q[`CFM_BIT_AVG_SEED];
	assign o_chan_off            = chan_q[7:1];

	// Assertions
	property p_mask_a_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[7] && !mask_a_q[7]) |=> o_irq_pulse;
	endproperty
	a_mask_a_gate: assert property (p_mask_a_gate) else $error("unmasked event lost");

	property p_mask_a_block;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt == 8'h40 && mask_a_q[6] && i_fault_b_evt == 8'h00 && !i_conv_done_evt)
			|=> !o_irq_pulse;
	endproperty
	a_mask_a_block: assert property (p_mask_a_block) else $error("masked event fired");

	property p_thermal;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[2] && !mask_b_q[2]) |=> o_irq_pulse;
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal event lost");

	property p_reserved_b;
		@(posedge i_clock) disable iff (i_rst)
		mask_b_q[1:0] == 2'h0 && chan_q[0] == 1'b0;
	endproperty
	a_reserved_b: assert property (p_reserved_b) else $error("reserved bit set");

	property p_watchdog;
		@(posedge i_clock) disable iff (i_rst)
		i_watchdog_expired && !i_reg_reset |=> !o_conv_enable;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog kept enable");

	property p_reg_reset;
		@(posedge i_clock) disable iff (i_rst)
		i_reg_reset |=> (setup_q == 8'h30 && mask_a_q == 8'h00
			&& mask_b_q == 8'h00 && chan_q == 8'h00);
	endproperty
	a_reg_reset: assert property (p_reg_reset) else $error("defaults not restored");

	property p_done_cont;
		@(posedge i_clock) disable iff (i_rst)
		(i_conv_done_evt && !o_conv_oneshot && i_fault_a_evt == 8'h00 && i_fault_b_evt == 8'h00)
			|=> !o_irq_pulse;
	endproperty
	a_done_cont: assert property (p_done_cont) else $error("done irq in continuous");

	property p_setup_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == 8'h2E && !i_watchdog_expired) |=> o_conv_resolution == $past(i_wdata[5:4]);
	endproperty
	a_setup_write: assert property (p_setup_write) else $error("resolution not stored");

	property p_chan_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == 8'h2F) |=> o_chan_off == $past(i_wdata[7:1]);
	endproperty
	a_chan_write: assert property (p_chan_write) else $error("channel bits not stored");

	// Unmasked bus over-voltage entry must pulse the interrupt
	property p_busov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[6] && !mask_a_q[6]) |=> o_irq_pulse;
	endproperty
	a_busov_gate: assert property (p_busov_gate) else $error("bus ov event lost");

	// Unmasked battery over-voltage entry must pulse the interrupt
	property p_battov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[5] && !mask_a_q[5]) |=> o_irq_pulse;
	endproperty
	a_battov_gate: assert property (p_battov_gate) else $error("batt ov event lost");

	// Unmasked input over-current must pulse the interrupt
	property p_inoc_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[4] && !mask_a_q[4]) |=> o_irq_pulse;
	endproperty
	a_inoc_gate: assert property (p_inoc_gate) else $error("input oc event lost");

	// Unmasked battery over-current must pulse the interrupt
	property p_battoc_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[3] && !mask_a_q[3]) |=> o_irq_pulse;
	endproperty
	a_battoc_gate: assert property (p_battoc_gate) else $error("batt oc event lost");

	// Unmasked converter over-current must pulse the interrupt
	property p_convoc_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[2] && !mask_a_q[2]) |=> o_irq_pulse;
	endproperty
	a_convoc_gate: assert property (p_convoc_gate) else $error("conv oc event lost");

	// Unmasked second adapter over-voltage must pulse the interrupt
	property p_in2ov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[1] && !mask_a_q[1]) |=> o_irq_pulse;
	endproperty
	a_in2ov_gate: assert property (p_in2ov_gate) else $error("input2 ov event lost");

	// Unmasked first adapter over-voltage must pulse the interrupt
	property p_in1ov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_a_evt[0] && !mask_a_q[0]) |=> o_irq_pulse;
	endproperty
	a_in1ov_gate: assert property (p_in1ov_gate) else $error("input1 ov event lost");

	// Unmasked system short must pulse the interrupt
	property p_sysshort_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[7] && !mask_b_q[7]) |=> o_irq_pulse;
	endproperty
	a_sysshort_gate: assert property (p_sysshort_gate) else $error("short event lost");

	// Unmasked system over-voltage must pulse the interrupt
	property p_sysov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[6] && !mask_b_q[6]) |=> o_irq_pulse;
	endproperty
	a_sysov_gate: assert property (p_sysov_gate) else $error("sys ov event lost");

	// Unmasked reverse over-voltage must pulse the interrupt
	property p_revov_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[5] && !mask_b_q[5]) |=> o_irq_pulse;
	endproperty
	a_revov_gate: assert property (p_revov_gate) else $error("rev ov event lost");

	// Unmasked reverse under-voltage must pulse the interrupt
	property p_revuv_gate;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[4] && !mask_b_q[4]) |=> o_irq_pulse;
	endproperty
	a_revuv_gate: assert property (p_revuv_gate) else $error("rev uv event lost");

	// A lone masked system short stays silent
	property p_mask_b_block;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt == 8'h80 && mask_b_q[7] && i_fault_a_evt == 8'h00 && !i_conv_done_evt)
			|=> !o_irq_pulse;
	endproperty
	a_mask_b_block: assert property (p_mask_b_block) else $error("masked short fired");

	// Events on the read-only bits alone never pulse the interrupt
	property p_reserved_evt;
		@(posedge i_clock) disable iff (i_rst)
		(i_fault_b_evt[7:2] == 6'h00 && i_fault_a_evt == 8'h00 && !i_conv_done_evt)
			|=> !o_irq_pulse;
	endproperty
	a_reserved_evt: assert property (p_reserved_evt) else $error("reserved event fired");

	// First mask stores every written bit
	property p_mask_a_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_MASK_A) |=> mask_a_q == $past(i_wdata);
	endproperty
	a_mask_a_write: assert property (p_mask_a_write) else $error("mask a not stored");

	// Second mask stores its writable bits and keeps bits 1-0 clear
	property p_mask_b_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_MASK_B) |=> mask_b_q == ($past(i_wdata) & 8'hFC);
	endproperty
	a_mask_b_write: assert property (p_mask_b_write) else $error("mask b not stored");

	// Enable follows a setup write when the watchdog is quiet
	property p_enable_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_SETUP && !i_watchdog_expired)
			|=> o_conv_enable == $past(i_wdata[7]);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable not stored");

	// Conversion mode follows a setup write
	property p_oneshot_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_SETUP) |=> o_conv_oneshot == $past(i_wdata[6]);
	endproperty
	a_oneshot_write: assert property (p_oneshot_write) else $error("mode not stored");

	// Averaging choice follows a setup write
	property p_avg_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_SETUP) |=> o_average_select == $past(i_wdata[3]);
	endproperty
	a_avg_write: assert property (p_avg_write) else $error("average not stored");

	// Average seed choice follows a setup write
	property p_seed_write;
		@(posedge i_clock) disable iff (i_rst)
		(write_ok && i_addr == `CFM_OFF_SETUP)
			|=> o_average_seed_select == $past(i_wdata[2]);
	endproperty
	a_seed_write: assert property (p_seed_write) else $error("seed not stored");

	// Second mask reads back with bits 1-0 clear
	property p_read_mask_b;
		@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_addr == `CFM_OFF_MASK_B) |=> (o_rdata_valid && o_rdata[1:0] == 2'h0);
	endproperty
	a_read_mask_b: assert property (p_read_mask_b) else $error("mask b reserved read");

	// Channel register reads back with bit 0 clear
	property p_read_chan;
		@(posedge i_clock) disable iff (i_rst)
		(i_rd && i_addr == `CFM_OFF_CHAN_A) |=> (o_rdata_valid && o_rdata[0] == 1'b0);
	endproperty
	a_read_chan: assert property (p_read_chan) else $error("channel reserved read");

endmodule

// File: cfm_host.sv
// Host-side model that drives register reads and writes into the bank.
// It assumes a free-running clock and the bank's one-cycle strobe port.
module cfm_host (
	// Clock
	input  wire logic       i_clock,
	// Access strobes towards the bank
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	// Read answer from the bank
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rdata_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// One write; address and data are scrambled once released
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
		@(posedge i_clock);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= w;
		@(posedge i_clock);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~w;
	endtask
	// One read; data is taken while the valid pulse stands
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clock);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clock);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(negedge i_clock);
		d = (i_rdata_valid === 1'b1) ? i_rdata : 8'hXX;
	endtask
endmodule

// File: testbench.sv
// Self-checking bench for the fault mask and converter setup bank.
// It assumes the host model and the bank share one 250 MHz clock.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_clock, i_rst, i_reg_reset, i_watchdog_expired;
	logic       i_conv_done_evt, i_conv_done_irq_off;
	logic       i_wr, i_rd, o_rdata_valid, o_irq_pulse, o_addr_hit;
	logic [7:0] i_addr, i_wdata, o_rdata, i_fault_a_evt, i_fault_b_evt, d, w;
	logic [7:0] sh [4];     // Shadow of the four registers
	logic [6:0] o_chan_off;
	logic       o_conv_enable, o_conv_oneshot, o_average_select, o_average_seed_select;
	cfm_pkg::cfm_res_e o_conv_resolution;
	int         seed, k, n, fails, total_checks, cycles;
	// Reset value and writable bits of each register
	function automatic logic [7:0] rv(int r);
		return (r == 2) ? 8'h30 : 8'h00;
	endfunction
	function automatic logic [7:0] wm(int r);
		return (r == 1) ? 8'hFC : (r == 3) ? 8'hFE : 8'hFF;
	endfunction
	// Whether an offset falls in the mapped window
	function automatic logic [7:0] hit(logic [7:0] a);
		return {7'h0, (a >= 8'h2C) && (a <= 8'h2F)};
	endfunction
	cfm_host host (.i_clock(i_clock), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
		.o_wdata(i_wdata), .i_rdata(o_rdata), .i_rdata_valid(o_rdata_valid));
	cfm_bank dut (.i_clock(i_clock), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
		.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.o_rdata_valid(o_rdata_valid), .o_addr_hit(o_addr_hit), .i_reg_reset(i_reg_reset),
		.i_watchdog_expired(i_watchdog_expired), .i_fault_a_evt(i_fault_a_evt),
		.i_fault_b_evt(i_fault_b_evt), .i_conv_done_evt(i_conv_done_evt),
		.i_conv_done_irq_off(i_conv_done_irq_off), .o_irq_pulse(o_irq_pulse),
		.o_conv_enable(o_conv_enable), .o_conv_oneshot(o_conv_oneshot),
		.o_conv_resolution(o_conv_resolution), .o_average_select(o_average_select),
		.o_average_seed_select(o_average_seed_select), .o_chan_off(o_chan_off));
	// Clock generator
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// Compare one byte and count it
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Pulse events for one cycle, then check the interrupt
	task automatic ev(input logic [7:0] a, input logic [7:0] b, input logic dn, input logic m);
		logic x;
		x = |(a & ~sh[0]) | |(b & ~sh[1] & 8'hFC) | (dn & ~m & sh[2][6]);
		@(posedge i_clock);
		i_fault_a_evt <= a;
		i_fault_b_evt <= b;
		i_conv_done_evt <= dn;
		i_conv_done_irq_off <= m;
		@(posedge i_clock);
		{i_fault_a_evt, i_fault_b_evt, i_conv_done_evt} <= '0;
		@(negedge i_clock);
		chk("irq", {7'h0, x}, {7'h0, o_irq_pulse});
	endtask
	// Write one register and keep its shadow
	task automatic put(input int r, input logic [7:0] v);
		host.wr_reg(8'h2C + r, v);
		sh[r] = v & wm(r);
	endtask
	// Address decode seen while a strobe stands
	always @(negedge i_clock) begin
		if (i_rd === 1'b1 || i_wr === 1'b1)
			chk("addr hit", hit(i_addr), {7'h0, o_addr_hit});
	end
	// Verdict and end of run
	task automatic wrap_up();
		if (fails == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			wrap_up();
		end
	end
	// Main sequence
	initial begin
		seed = 7492;
		{i_rst, i_reg_reset, i_watchdog_expired} = 3'b100;
		{i_fault_a_evt, i_fault_b_evt, i_conv_done_evt, i_conv_done_irq_off} = '0;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		for (k = 0; k < 4; k++) begin
			host.rd_reg(8'h2C + k, d);
			chk("reset value", rv(k), d);
			sh[k] = rv(k);
		end
		host.rd_reg(8'h30, d);
		chk("unmapped read", 8'h00, d);
		ev(8'hFF, 8'hFF, 1'b1, 1'b0);
		for (n = 0; n < 300; n++) begin
			k = $unsigned($random(seed)) % 4;
			w = (n % 50 == 7) ? 8'hFF : $random(seed);
			put(k, w);
			host.rd_reg(8'h2C + k, d);
			chk("register", sh[k], d);
			chk("setup out", sh[2] & 8'hFC, {o_conv_enable, o_conv_oneshot, o_conv_resolution,
				o_average_select, o_average_seed_select, 2'b00});
			chk("channels", sh[3], {o_chan_off, 1'b0});
			w = $random(seed);
			ev(8'h01 << (n % 8), 8'h01 << ((n + 3) % 8), w[0], w[1]);
		end
		// Corners: lone masked events, read-only events, done in each mode
		put(0, 8'h40);
		put(1, 8'h80);
		put(2, 8'h30);
		ev(8'h40, 8'h00, 1'b0, 1'b0);
		ev(8'h00, 8'h80, 1'b0, 1'b0);
		ev(8'h00, 8'h03, 1'b0, 1'b0);
		ev(8'h00, 8'h00, 1'b1, 1'b0);
		put(2, 8'h70);
		ev(8'h00, 8'h00, 1'b1, 1'b0);
		ev(8'h00, 8'h00, 1'b1, 1'b1);
		ev(8'h80, 8'h04, 1'b0, 1'b0);
		host.wr_reg(8'h2E, 8'hFF);
		@(posedge i_clock) i_watchdog_expired <= 1'b1;
		@(posedge i_clock) i_watchdog_expired <= 1'b0;
		host.rd_reg(8'h2E, d);
		chk("after watchdog", 8'h7F, d);
		@(posedge i_clock) i_reg_reset <= 1'b1;
		@(posedge i_clock) i_reg_reset <= 1'b0;
		for (k = 0; k < 4; k++) begin
			host.rd_reg(8'h2C + k, d);
			chk("after reg reset", rv(k), d);
		end
		// Mid-run reset must bring the channel register back to zero
		put(3, 8'hAA);
		@(posedge i_clock) i_rst <= 1'b1;
		@(posedge i_clock) i_rst <= 1'b0;
		host.rd_reg(8'h2F, d);
		chk("after mid-run reset", 8'h00, d);
		wrap_up();
	end
endmodule
